// *** include/rtc_consts.svh ***
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// ************************************************************
// register map, byte addresses
// ************************************************************
`define RTC_REG_CTRL 5'h00
`define RTC_REG_POL 5'h04
`define RTC_REG_STAT 5'h08
`define RTC_REG_PROC 5'h0C
`define RTC_REG_EVT 5'h10

// ************************************************************
// reset values and field positions
// ************************************************************
`define RTC_CTRL_RST 16'h0000
`define RTC_POL_RST 8'h00
`define RTC_CTRL_AUTO_LSB 8
`define RTC_EVT_LOG_BIT 0

// ************************************************************
// input vector layout
// ************************************************************
`define RTC_IN_GA 0
`define RTC_IN_GB 1
`define RTC_IN_BAKE 2
`define RTC_IN_EMINH 3
`define RTC_IN_KEYINH 4
`define RTC_IN_TA 5
`define RTC_IN_TB 6
`define RTC_IN_LOG 7
`define RTC_IN_IGN 8
`define RTC_IN_FA 9
`define RTC_IN_FB 10
`define RTC_IN_PANINH 11
`define RTC_IN_PROC 12
`define RTC_IN_NUM 20
`define RTC_IN_IDLE 20'hFFFFF

// ************************************************************
// timing
// ************************************************************
`define RTC_CLK_NS 40
`define RTC_FILT_NS 1000

`endif

// *** include/rtc_pkg.sv ***
package rtc_pkg;
   typedef logic [7:0] rtc_chan_t;
   typedef logic [31:0] rtc_word_t;
   typedef logic [4:0] rtc_addr_t;
   typedef logic [4:0] rtc_fcnt_t;
endpackage : rtc_pkg

// *** tb/rtc_equip_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"

// ************************************************************
// external process equipment driving the connector pins
// ************************************************************
module rtc_equip_model
   import rtc_pkg::*;
(
   input wire logic [19:0] pinCmd, // levels the equipment presents
   output logic gaugeAEmissionRequest, // to device pin
   output logic gaugeBEmissionRequest, // to device pin
   output logic bakeoutRequest, // to device pin
   output logic emissionInhibitN, // to device pin
   output logic gaugeKeypadInhibitN, // to device pin
   output logic thermalGaugeAOffRequest, // to device pin
   output logic thermalGaugeBOffRequest, // to device pin
   output logic logEraseN, // to device pin
   output logic remoteGaugeIgnore, // to device pin
   output logic filamentASelect, // to device pin
   output logic filamentBSelect, // to device pin
   output logic panelInhibitN, // to device pin
   output rtc_chan_t procInN // channel input pins
);
   // a low is made by pulling the pin to ground, a high by the pull-up
   assign gaugeAEmissionRequest = pinCmd[`RTC_IN_GA];
   assign gaugeBEmissionRequest = pinCmd[`RTC_IN_GB];
   assign bakeoutRequest = pinCmd[`RTC_IN_BAKE];
   assign emissionInhibitN = pinCmd[`RTC_IN_EMINH];
   assign gaugeKeypadInhibitN = pinCmd[`RTC_IN_KEYINH];
   assign thermalGaugeAOffRequest = pinCmd[`RTC_IN_TA];
   assign thermalGaugeBOffRequest = pinCmd[`RTC_IN_TB];
   assign logEraseN = pinCmd[`RTC_IN_LOG];
   assign remoteGaugeIgnore = pinCmd[`RTC_IN_IGN];
   assign filamentASelect = pinCmd[`RTC_IN_FA];
   assign filamentBSelect = pinCmd[`RTC_IN_FB];
   assign panelInhibitN = pinCmd[`RTC_IN_PANINH];
   assign procInN = pinCmd[`RTC_IN_PROC +: 8];
endmodule : rtc_equip_model

`default_nettype wire

// *** tb/rtc_remote_io_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"

module rtc_remote_io_test
   import rtc_pkg::*;
;
   logic core_clk, nrst, read, write, waitrequest;
   rtc_addr_t address;
   rtc_word_t writedata, readdata, d;
   logic [19:0] pinCmd;
   wire logic gA, gB, bake, emInh, keyInh, tA, tB, logE, ign, fA, fB, panInh;
   wire rtc_chan_t procInN;
   rtc_chan_t chanOutN;
   wire logic [6:0] st;
   logic [6:0] expSt;
   logic keysBlk, panBlk, clrPulse;
   int fails, compares, pulses;
   int pinIdx[7] = '{0, 1, 2, 5, 6, 9, 10};
   bit onFall[7] = '{1, 1, 1, 0, 0, 1, 1};

   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) if (clrPulse === 1'b1) pulses++;

   rtc_equip_model i_equip (.pinCmd(pinCmd), .gaugeAEmissionRequest(gA),
      .gaugeBEmissionRequest(gB), .bakeoutRequest(bake),
      .emissionInhibitN(emInh), .gaugeKeypadInhibitN(keyInh),
      .thermalGaugeAOffRequest(tA), .thermalGaugeBOffRequest(tB),
      .logEraseN(logE), .remoteGaugeIgnore(ign), .filamentASelect(fA),
      .filamentBSelect(fB), .panelInhibitN(panInh), .procInN(procInN));

   rtc_remote_io i_dut (.core_clk(core_clk), .nrst(nrst),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .gaugeAEmissionRequest(gA),
      .gaugeBEmissionRequest(gB), .bakeoutRequest(bake),
      .emissionInhibitN(emInh), .gaugeKeypadInhibitN(keyInh),
      .thermalGaugeAOffRequest(tA), .thermalGaugeBOffRequest(tB),
      .logEraseN(logE), .remoteGaugeIgnore(ign), .filamentASelect(fA),
      .filamentBSelect(fB), .panelInhibitN(panInh), .procInN(procInN),
      .chanOutN(chanOutN), .ionGaugeAEmission(st[0]),
      .ionGaugeBEmission(st[1]), .degasOn(st[2]),
      .thermalGaugeAOn(st[3]), .thermalGaugeBOn(st[4]),
      .filamentAOn(st[5]), .filamentBOn(st[6]),
      .gaugeKeysBlocked(keysBlk), .panelBlocked(panBlk),
      .logClearPulse(clrPulse));

   // ************************************************************
   // checking and closing
   // ************************************************************
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input rtc_word_t seen,
      input rtc_word_t exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // ************************************************************
   // avalon master: hold request until waitrequest sampled low
   // ************************************************************
   task automatic bus(input bit wr, input rtc_addr_t a, input rtc_word_t wd,
      output rtc_word_t rd);
      int n;
      n = 0;
      @(posedge core_clk);
      address <= a;
      writedata <= wd;
      read <= !wr;
      write <= wr;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 50);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 50)
      begin
         fails++;
         wrap_up();
      end
   endtask : bus

   // pin filter plus sync costs at most 29 cycles; 35 leaves margin
   task automatic pin(input int idx, input bit v, input int hold = 35);
      @(posedge core_clk);
      pinCmd[idx] <= v;
      repeat (hold) @(posedge core_clk);
   endtask : pin

   task automatic chkStat;
      bus(0, `RTC_REG_STAT, '0, d);
      chk("stat", d, {20'h0, pinCmd[`RTC_IN_IGN], !pinCmd[`RTC_IN_PANINH],
         !pinCmd[`RTC_IN_KEYINH], !pinCmd[`RTC_IN_EMINH], expSt, 1'b0});
      chk("state", {25'h0, st}, {25'h0, expSt});
   endtask : chkStat

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      core_clk = 0; nrst = 0; read = 0; write = 0;
      address = '0; writedata = '0; pinCmd = `RTC_IN_IDLE;
      fails = 0; compares = 0; pulses = 0; expSt = 7'h18;
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk("chanOutN", {24'h0, chanOutN}, 32'hFF);
      bus(0, `RTC_REG_CTRL, '0, d);
      chk("ctrl", d, {16'h0, `RTC_CTRL_RST});
      bus(0, `RTC_REG_POL, '0, d);
      chk("pol", d, {24'h0, `RTC_POL_RST});
      bus(1, 5'h14, 32'hFFFF, d);
      bus(0, 5'h14, '0, d);
      chk("unmapped", d, '0);
      chkStat();
      // an idle ignore pin floats high and would freeze the requests
      pin(`RTC_IN_IGN, 0);
      chkStat();
      for (int i = 0; i < 7; i++)
      begin
         pin(pinIdx[i], 0);
         expSt[i] = onFall[i];
         chkStat();
         pin(pinIdx[i], 1);
         expSt[i] = !onFall[i];
         chkStat();
      end
      // a glitch shorter than the filter must not act
      pin(`RTC_IN_GA, 0, 10);
      pin(`RTC_IN_GA, 1);
      chkStat();
      // lockout drops a running emission and blocks new ones
      pin(`RTC_IN_GA, 0);
      expSt[0] = 1;
      pin(`RTC_IN_EMINH, 0);
      expSt[0] = 0;
      chkStat();
      pin(`RTC_IN_GA, 1);
      pin(`RTC_IN_GB, 0);
      pin(`RTC_IN_GA, 0);
      chkStat();
      pin(`RTC_IN_EMINH, 1);
      chkStat();
      pin(`RTC_IN_GA, 1);
      pin(`RTC_IN_GB, 1);
      // ignore input freezes gauge, bake and filament requests
      pin(`RTC_IN_IGN, 1);
      pin(`RTC_IN_GB, 0);
      pin(`RTC_IN_BAKE, 0);
      pin(`RTC_IN_FA, 0);
      chkStat();
      pin(`RTC_IN_GB, 1);
      pin(`RTC_IN_BAKE, 1);
      pin(`RTC_IN_FA, 1);
      pin(`RTC_IN_IGN, 0);
      chkStat();
      pin(`RTC_IN_KEYINH, 0);
      chk("keys", {31'h0, keysBlk}, 32'h1);
      chkStat();
      pin(`RTC_IN_KEYINH, 1);
      chk("keys", {31'h0, keysBlk}, 32'h0);
      pin(`RTC_IN_PANINH, 0);
      chk("panel", {31'h0, panBlk}, 32'h1);
      pin(`RTC_IN_PANINH, 1);
      chk("panel", {31'h0, panBlk}, 32'h0);
      // log erase: falling edge only, one pulse, sticky flag
      pulses = 0;
      pin(`RTC_IN_LOG, 0);
      chk("pulses", pulses, 1);
      pin(`RTC_IN_LOG, 1);
      chk("pulses", pulses, 1);
      bus(0, `RTC_REG_EVT, '0, d);
      chk("evt", d, 32'h1);
      bus(1, `RTC_REG_EVT, 32'h1, d);
      bus(0, `RTC_REG_EVT, '0, d);
      chk("evt", d, 32'h0);
      // manual channels, then automatic with mixed polarity
      bus(1, `RTC_REG_CTRL, 32'h00A5, d);
      repeat (3) @(posedge core_clk);
      chk("chanOutN", {24'h0, chanOutN}, 32'h5A);
      bus(1, `RTC_REG_POL, 32'h0F, d);
      bus(1, `RTC_REG_CTRL, 32'hFF00, d);
      repeat (3) @(posedge core_clk);
      chk("chanOutN", {24'h0, chanOutN}, 32'hF0);
      @(posedge core_clk);
      pinCmd[`RTC_IN_PROC +: 8] <= 8'h00;
      repeat (35) @(posedge core_clk);
      chk("chanOutN", {24'h0, chanOutN}, 32'h0F);
      bus(0, `RTC_REG_PROC, '0, d);
      chk("proc", d, 32'hF000);
      wrap_up();
   end
endmodule : rtc_remote_io_test

`default_nettype wire

// *** verilog/rtc_remote_io.sv ***
// Function
// - eight outputs, eight inputs, twelve remote inputs
// - ion gauge request: fall on, rise off
// - bake-out request: fall starts, rise stops
// - emission inhibit low forces both emissions off
// - keypad inhibit low blocks gauge keys
// - thermal gauge A: fall off, rise on
// - thermal gauge B: fall off, rise on
// - log erase falling edge clears log
// - ignore high freezes emission, bake, filaments
// - filament select: fall on, rise off
// - panel inhibit low blocks touchscreen, keypad
// - channel outputs are active low
// - per-channel polarity picks activating input level
`include "rtc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module rtc_remote_io
   import rtc_pkg::*;
(
   input wire logic core_clk, // 25 MHz core clock
   input wire logic nrst, // async reset, active low
   input wire rtc_addr_t address, // avalon byte address
   input wire logic read, // avalon read
   input wire logic write, // avalon write
   input wire rtc_word_t writedata, // avalon write data
   output rtc_word_t readdata, // avalon read data
   output logic waitrequest, // avalon wait
   input wire logic gaugeAEmissionRequest, // pin, edge
   input wire logic gaugeBEmissionRequest, // pin, edge
   input wire logic bakeoutRequest, // pin, edge
   input wire logic emissionInhibitN, // pin, level
   input wire logic gaugeKeypadInhibitN, // pin, level
   input wire logic thermalGaugeAOffRequest, // pin, edge
   input wire logic thermalGaugeBOffRequest, // pin, edge
   input wire logic logEraseN, // pin, falling edge
   input wire logic remoteGaugeIgnore, // pin, level
   input wire logic filamentASelect, // pin, edge
   input wire logic filamentBSelect, // pin, edge
   input wire logic panelInhibitN, // pin, level
   input wire rtc_chan_t procInN, // channel input pins
   output rtc_chan_t chanOutN, // channel outputs, low=active
   output logic ionGaugeAEmission, // gauge A emission on
   output logic ionGaugeBEmission, // gauge B emission on
   output logic degasOn, // degas running
   output logic thermalGaugeAOn, // thermal gauge A on
   output logic thermalGaugeBOn, // thermal gauge B on
   output logic filamentAOn, // filament A selected
   output logic filamentBOn, // filament B selected
   output logic gaugeKeysBlocked, // gauge keys ignored
   output logic panelBlocked, // touchscreen and keypad ignored
   output logic logClearPulse // one-cycle log clear
);

   // ************************************************************
   // reset release
   // ************************************************************
   logic rstMetaR;
   logic rstSyncR;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rstMetaR <= 1'b0;
         rstSyncR <= 1'b0;
      end
      else
      begin
         rstMetaR <= 1'b1;
         rstSyncR <= rstMetaR;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstSyncR);

   // ************************************************************
   // input synchronisers and glitch filter
   // ************************************************************
   localparam int FILT_CYC =
      (`RTC_FILT_NS + `RTC_CLK_NS - 1) / `RTC_CLK_NS;
   localparam rtc_fcnt_t FILT_LAST = rtc_fcnt_t'(FILT_CYC - 1);

   wire logic [`RTC_IN_NUM-1:0] rawIn;
   logic [`RTC_IN_NUM-1:0] syncAR;
   logic [`RTC_IN_NUM-1:0] syncBR;
   wire logic [`RTC_IN_NUM-1:0] fltR;
   logic [`RTC_IN_NUM-1:0] fltPrevR;
   wire logic [`RTC_IN_NUM-1:0] fall;
   wire logic [`RTC_IN_NUM-1:0] rise;

   // all pins idle high, so flops reset high to avoid false edges
   assign rawIn = {procInN, panelInhibitN, filamentBSelect,
      filamentASelect, remoteGaugeIgnore, logEraseN,
      thermalGaugeBOffRequest, thermalGaugeAOffRequest,
      gaugeKeypadInhibitN, emissionInhibitN, bakeoutRequest,
      gaugeBEmissionRequest, gaugeAEmissionRequest};

   always_ff @(posedge core_clk or negedge rstSyncR)
   begin
      if (!rstSyncR)
      begin
         syncAR <= `RTC_IN_IDLE;
         syncBR <= `RTC_IN_IDLE;
         fltPrevR <= `RTC_IN_IDLE;
      end
      else
      begin
         syncAR <= rawIn;
         syncBR <= syncAR;
         fltPrevR <= fltR;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `RTC_IN_NUM; gi++)
      begin : g_filt
         rtc_fcnt_t cntR;
         logic bitR;
         // one process per bit, so the vector is gathered as a net
         assign fltR[gi] = bitR;
         // a level must hold FILT_CYC cycles before it is believed
         always_ff @(posedge core_clk or negedge rstSyncR)
         begin
            if (!rstSyncR)
            begin
               cntR <= '0;
               bitR <= 1'b1;
            end
            else if (syncBR[gi] == bitR)
               cntR <= '0;
            else if (cntR == FILT_LAST)
            begin
               cntR <= '0;
               bitR <= syncBR[gi];
            end
            else
               cntR <= cntR + 5'h01;
         end
      end
   endgenerate

   assign fall = fltPrevR & ~fltR;
   assign rise = ~fltPrevR & fltR;

   // ************************************************************
   // remote control decoding
   // ************************************************************
   wire logic ignore;
   wire logic emisOk;
   wire logic emisANxt;
   wire logic emisBNxt;
   wire logic degasNxt;
   wire logic filANxt;
   wire logic filBNxt;
   wire logic thermANxt;
   wire logic thermBNxt;

   function automatic logic edgeNext(input logic cur,
      input logic setEv, input logic clrEv);
      edgeNext = setEv ? 1'b1 : (clrEv ? 1'b0 : cur);
   endfunction : edgeNext

   assign ignore = fltR[`RTC_IN_IGN];
   assign emisOk = fltR[`RTC_IN_EMINH];
   // lockout clears emission; a fresh falling edge is needed after it
   assign emisANxt = emisOk & edgeNext(ionGaugeAEmission,
      fall[`RTC_IN_GA] & ~ignore, rise[`RTC_IN_GA] & ~ignore);
   assign emisBNxt = emisOk & edgeNext(ionGaugeBEmission,
      fall[`RTC_IN_GB] & ~ignore, rise[`RTC_IN_GB] & ~ignore);
   assign degasNxt = edgeNext(degasOn, fall[`RTC_IN_BAKE] & ~ignore,
      rise[`RTC_IN_BAKE] & ~ignore);
   assign filANxt = edgeNext(filamentAOn, fall[`RTC_IN_FA] & ~ignore,
      rise[`RTC_IN_FA] & ~ignore);
   assign filBNxt = edgeNext(filamentBOn, fall[`RTC_IN_FB] & ~ignore,
      rise[`RTC_IN_FB] & ~ignore);
   assign thermANxt = edgeNext(thermalGaugeAOn, rise[`RTC_IN_TA],
      fall[`RTC_IN_TA]);
   assign thermBNxt = edgeNext(thermalGaugeBOn, rise[`RTC_IN_TB],
      fall[`RTC_IN_TB]);

   always_ff @(posedge core_clk or negedge rstSyncR)
   begin
      if (!rstSyncR)
      begin
         ionGaugeAEmission <= 1'b0;
         ionGaugeBEmission <= 1'b0;
         degasOn <= 1'b0;
         filamentAOn <= 1'b0;
         filamentBOn <= 1'b0;
         thermalGaugeAOn <= 1'b1;
         thermalGaugeBOn <= 1'b1;
         gaugeKeysBlocked <= 1'b0;
         panelBlocked <= 1'b0;
         logClearPulse <= 1'b0;
      end
      else
      begin
         ionGaugeAEmission <= emisANxt;
         ionGaugeBEmission <= emisBNxt;
         degasOn <= degasNxt;
         filamentAOn <= filANxt;
         filamentBOn <= filBNxt;
         thermalGaugeAOn <= thermANxt;
         thermalGaugeBOn <= thermBNxt;
         gaugeKeysBlocked <= ~fltR[`RTC_IN_KEYINH];
         panelBlocked <= ~fltR[`RTC_IN_PANINH];
         logClearPulse <= fall[`RTC_IN_LOG];
      end
   end

   // ************************************************************
   // process channels
   // ************************************************************
   rtc_chan_t manualR;
   rtc_chan_t autoR;
   rtc_chan_t polR;
   wire rtc_chan_t procLvl;
   wire rtc_chan_t chanAct;

   assign procLvl = fltR[`RTC_IN_PROC +: 8];
   // polarity bit 1 means a high input activates the channel
   assign chanAct = (autoR & ~(procLvl ^ polR))
      | (~autoR & manualR);

   always_ff @(posedge core_clk or negedge rstSyncR)
   begin
      if (!rstSyncR)
         chanOutN <= 8'hFF;
      else
         chanOutN <= ~chanAct;
   end

   // ************************************************************
   // avalon slave, one wait cycle per access
   // ************************************************************
   wire logic req;
   wire logic wrEff;
   wire logic hitCtrl;
   wire logic hitPol;
   wire logic hitStat;
   wire logic hitProc;
   wire logic hitEvt;
   wire rtc_word_t rdMux;
   logic logEvtR;

   assign req = read | write;
   assign wrEff = write & ~waitrequest;
   assign hitCtrl = address == `RTC_REG_CTRL;
   assign hitPol = address == `RTC_REG_POL;
   assign hitStat = address == `RTC_REG_STAT;
   assign hitProc = address == `RTC_REG_PROC;
   assign hitEvt = address == `RTC_REG_EVT;
   // unmapped addresses read zero and ignore writes
   assign rdMux =
      ({32{hitCtrl}} & {16'h0000, autoR, manualR})
      | ({32{hitPol}} & {24'h000000, polR})
      | ({32{hitStat}} & {20'h00000, ignore, panelBlocked,
         gaugeKeysBlocked, ~emisOk, filamentBOn, filamentAOn,
         thermalGaugeBOn, thermalGaugeAOn, degasOn,
         ionGaugeBEmission, ionGaugeAEmission, 1'b0})
      | ({32{hitProc}} & {16'h0000, ~chanOutN, procLvl})
      | ({32{hitEvt}} & {31'h00000000, logEvtR});

   always_ff @(posedge core_clk or negedge rstSyncR)
   begin
      if (!rstSyncR)
      begin
         waitrequest <= 1'b1;
         readdata <= '0;
      end
      else
      begin
         waitrequest <= ~(req & waitrequest);
         if (read & waitrequest)
            readdata <= rdMux;
      end
   end

   always_ff @(posedge core_clk or negedge rstSyncR)
   begin
      if (!rstSyncR)
      begin
         manualR <= 8'(`RTC_CTRL_RST);
         autoR <= 8'(`RTC_CTRL_RST >> `RTC_CTRL_AUTO_LSB);
         polR <= `RTC_POL_RST;
      end
      else if (wrEff & hitCtrl)
      begin
         manualR <= writedata[7:0];
         autoR <= writedata[`RTC_CTRL_AUTO_LSB +: 8];
      end
      else if (wrEff & hitPol)
         polR <= writedata[7:0];
   end

   // sticky log-clear flag; a new edge wins over a clear
   always_ff @(posedge core_clk or negedge rstSyncR)
   begin
      if (!rstSyncR)
         logEvtR <= 1'b0;
      else if (fall[`RTC_IN_LOG])
         logEvtR <= 1'b1;
      else if (wrEff & hitEvt & writedata[`RTC_EVT_LOG_BIT])
         logEvtR <= 1'b0;
   end

   // ************************************************************
   // checks
   // ************************************************************
   a_emis_lockout: assert property (
      !emisOk |=> !ionGaugeAEmission && !ionGaugeBEmission)
      else $error("emission on during lockout");
   a_gauge_on: assert property (
      fall[`RTC_IN_GA] && !ignore && emisOk |=> ionGaugeAEmission)
      else $error("gauge A not switched on");
   a_gauge_off: assert property (
      rise[`RTC_IN_GB] && !ignore |=> !ionGaugeBEmission)
      else $error("gauge B not switched off");
   a_degas_edge: assert property (
      fall[`RTC_IN_BAKE] && !ignore |=> degasOn)
      else $error("degas not started");
   a_thermal_a_off: assert property (
      fall[`RTC_IN_TA] |=> !thermalGaugeAOn)
      else $error("thermal A not off");
   a_thermal_b_on: assert property (
      rise[`RTC_IN_TB] |=> thermalGaugeBOn)
      else $error("thermal B not on");
   a_log_pulse: assert property (
      fall[`RTC_IN_LOG] |=> logClearPulse ##1 !logClearPulse
         && logEvtR)
      else $error("log clear pulse wrong");
   a_ignore_hold: assert property (
      ignore && $stable(ignore) |=> $stable(filamentAOn)
         && $stable(degasOn))
      else $error("request acted on while ignored");
   a_fil_on: assert property (
      fall[`RTC_IN_FB] && !ignore |=> filamentBOn)
      else $error("filament B not on");
   a_panel_block: assert property (
      !fltR[`RTC_IN_PANINH] && !fltR[`RTC_IN_KEYINH]
         |=> panelBlocked && gaugeKeysBlocked)
      else $error("panel not blocked");
   a_chan_auto: assert property (
      autoR[0] && procLvl[0] == polR[0] |=> !chanOutN[0])
      else $error("auto channel 0 not active low");
   a_filter_hold: assert property (
      $changed(fltR[`RTC_IN_GA]) |->
         $past(g_filt[`RTC_IN_GA].cntR) == FILT_LAST
         && $past(syncBR[`RTC_IN_GA]) == fltR[`RTC_IN_GA])
      else $error("filter passed a short pulse");
   a_bus_answer: assert property (
      req && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("bus answer timing wrong");

endmodule : rtc_remote_io

`default_nettype wire
